/* File: pkg/dma_ctrl_pkg.sv */
// Constants for the DMA request sampling and termination control.
// Assumes one bus clock; every delay below is in bus clock states.
//
// Contract
// - Request pin sampled as a falling edge or as a low level.
// - Transfer bus cycle starts no sooner than three states after detection.
// - Second request sample starts two cycles after the first.
// - Cycle-steal uses one sampling schedule for level and edge detection.
// - Undetected second sample repeats every cycle until a request is seen; code skips sampling in write states while a unit is pending.
// - Cycle-steal third sample waits for the idle cycle after first transfer.
// - Acknowledge spans exactly the chip select of the chosen access.
// - Burst level samples like cycle-steal, later samples in idle cycle.
// - Burst edge samples once, then runs until the count is exhausted.
// - Channel 2 reload restores working source address every four transfers.
// - Reload counter cleared by disable, end flag, abort, reset or standby.
// - On ending, new requests refused, accepted transfers finished, then stop.
// - Burst edge stop follows cycle-steal schedule; unsampled periods count active.
// - Suspension only at a unit boundary; write always follows its read.
// - Count zero sets end flag and raises interrupt when enabled.
// - Channel enable cleared halts channel without setting end flag.
// - Abort event sets flag, stops all channels, resumes after flag cleared.
// - Master enable cleared aborts all channels, end flags stay clear.
// - Access length taken from bus state controller wait setting.
// - Burst level with request high releases bus after accepted request.
// - Bus mode chosen per channel from its bus mode select bit.

package dma_ctrl_pkg;
    localparam int NUM_CH        = 4;
    localparam int CNT_W         = 16;
    localparam int ADDR_W        = 32;
    localparam int DATA_W        = 32;
    localparam int WAIT_W        = 4;
    localparam int FIFO_DEPTH    = 8;
    localparam int RELOAD_CH     = 2;
    localparam int START_STATES  = 3;
    localparam int SECOND_GAP    = 2;
    localparam int RELOAD_PERIOD = 4;
    localparam int MAX_PENDING   = 2;
    localparam logic [1:0] RELOAD_LAST   = 2'h3;
    localparam logic [1:0] PEND_MAX      = 2'h2;
    localparam logic [1:0] START_LOAD    = 2'h1;
    localparam logic [1:0] GAP_LOAD      = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0002;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_READ  = 3'b011,
        ST_WRITE = 3'b010,
        ST_GAP   = 3'b110
    } xfer_state_t;
endpackage

/* File: rtl/dma_xfer_fifo.sv */
// Small flip-flop FIFO for read data leaving the engine.
// Assumes producer and consumer share clk; full blocks new transfers upstream.
`timescale 1ns/1ps
`default_nettype none
module dma_xfer_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << PW) != DEPTH)
            $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ff;
    logic [PW-1:0]    rd_ff;
    logic [PW:0]      fill_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (fill_ff != DEPTH[PW:0]);
    assign out_valid = (fill_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rd_ff];

    always_ff @(posedge clk)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_ff   <= '0;
            rd_ff   <= '0;
            fill_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= wr_ff + 1'b1;
            if (pop)
                rd_ff <= rd_ff + 1'b1;
            if (push && !pop)
                fill_ff <= fill_ff + 1'b1;
            else if (pop && !push)
                fill_ff <= fill_ff - 1'b1;
        end
    end

    a_fifo_no_overfill : assert property (@(posedge clk) disable iff (srst)
        fill_ff <= DEPTH[PW:0])
        else $error("fifo fill beyond depth");
endmodule
`default_nettype wire

/* File: rtl/dma_request_control.sv */
// Request sampling, channel 2 reload and termination for a four-channel DMA.
// Assumes request pin is asynchronous; grant and wait setting come from bus logic.
`timescale 1ns/1ps
`default_nettype none
module dma_request_control
    import dma_ctrl_pkg::*;
#(
    parameter int NCH = NUM_CH,
    parameter int CW  = CNT_W
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              dma_request_pin_n,
    output logic                   dma_ack_pin,
    output logic                   area_chip_select_n,
    output logic                   bus_request,
    input  wire logic              bus_grant,
    input  wire logic [WAIT_W-1:0] bsc_wait_states,
    input  wire logic [DATA_W-1:0] bus_rdata,
    input  wire logic              master_enable,
    input  wire logic [NCH-1:0]    channel_enable,
    input  wire logic [NCH-1:0]    bus_mode_select,
    input  wire logic [NCH-1:0]    edge_detect,
    input  wire logic [NCH-1:0]    ack_on_write,
    input  wire logic [NCH-1:0]    end_interrupt_enable,
    input  wire logic [NCH-1:0]    count_load,
    input  wire logic [CW-1:0]     count_load_value,
    input  wire logic [NCH-1:0]    end_flag_clear,
    output logic      [NCH-1:0]    transfer_end_flag,
    output logic                   transfer_end_interrupt,
    input  wire logic              nmi_event,
    input  wire logic              nmi_flag_clear,
    output logic                   nmi_abort_flag,
    input  wire logic              standby,
    input  wire logic              reload_enable,
    input  wire logic              ch2_source_load,
    input  wire logic [ADDR_W-1:0] ch2_source_value,
    output logic      [ADDR_W-1:0] ch2_source_address,
    output logic                   xfer_valid,
    input  wire logic              xfer_ready,
    output logic      [DATA_W-1:0] xfer_data
);
    localparam int IW = $clog2(NCH);

    initial
    begin
        if (NCH <= RELOAD_CH || NCH > 16 || CW < 2)
            $error("channel count or count width not supported");
    end

    xfer_state_t    state_ff;
    logic           req_meta_ff;
    logic           req_sync_ff;
    logic           req_prev_ff;
    logic [CW-1:0]  count_ff [NCH];
    logic [NCH-1:0] eligible;
    logic [IW-1:0]  cur_ff;
    logic [IW-1:0]  pick;
    logic           any_elig;
    logic           active_ff;
    logic [1:0]     pend_ff;
    logic [1:0]     samp_dly_ff;
    logic [1:0]     start_ff;
    logic [WAIT_W-1:0] acc_ff;
    logic           burst_edge_ff;
    logic [1:0]     reload_cnt_ff;
    logic [ADDR_W-1:0] ch2_prog_ff;
    logic           run_ok;
    logic           sample_now;
    logic           req_hit;
    logic           accept;
    logic           unit_done;
    logic           last_unit;
    logic           fifo_ready;
    logic           is_burst;

    // Pin reaches logic only after two flops
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            req_meta_ff <= 1'b1;
            req_sync_ff <= 1'b1;
            req_prev_ff <= 1'b1;
        end
        else
        begin
            req_meta_ff <= dma_request_pin_n;
            req_sync_ff <= req_meta_ff;
            req_prev_ff <= req_sync_ff;
        end
    end

    // Fixed priority, lowest channel first
    always_comb
    begin
        pick     = '0;
        any_elig = 1'b0;
        for (int i = NCH - 1; i >= 0; i--)
        begin
            if (eligible[i])
            begin
                pick     = IW'(i);
                any_elig = 1'b1;
            end
        end
    end

    assign run_ok   = active_ff ? eligible[cur_ff] : any_elig;
    assign is_burst = bus_mode_select[active_ff ? cur_ff : pick];

    assign sample_now = run_ok && samp_dly_ff == 2'h0 && pend_ff < PEND_MAX
                        && (state_ff != ST_WRITE || pend_ff == 2'h0);
    assign req_hit = burst_edge_ff
                   || (edge_detect[active_ff ? cur_ff : pick] ? (req_prev_ff && !req_sync_ff) : !req_sync_ff);
    assign accept    = sample_now && req_hit;
    assign unit_done = (state_ff == ST_WRITE) && acc_ff == '0;
    assign last_unit = unit_done && count_ff[cur_ff] == CW'(1);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            active_ff     <= 1'b0;
            cur_ff        <= '0;
            burst_edge_ff <= 1'b0;
        end
        else if (!active_ff && accept)
        begin
            active_ff     <= 1'b1;
            cur_ff        <= pick;
            burst_edge_ff <= bus_mode_select[pick] && edge_detect[pick];
        end
        // Keep the channel while a fresh request is taken from idle
        else if (active_ff && (last_unit || (state_ff == ST_IDLE && pend_ff == 2'h0 && !accept)))
        begin
            active_ff     <= 1'b0;
            burst_edge_ff <= 1'b0;
        end
        else if (!run_ok)
            burst_edge_ff <= 1'b0;
    end

    // Accepted work drained, new work refused
    always_ff @(posedge clk)
    begin
        if (srst)
            pend_ff <= 2'h0;
        else if (last_unit)
            pend_ff <= 2'h0;
        else
            pend_ff <= pend_ff + {1'b0, accept} - {1'b0, unit_done};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            samp_dly_ff <= 2'h0;
        else if (accept)
            samp_dly_ff <= 2'(SECOND_GAP - 1);
        else if (samp_dly_ff != 2'h0)
            samp_dly_ff <= samp_dly_ff - 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff <= ST_IDLE;
            start_ff <= '0;
            acc_ff   <= '0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (accept)
                    begin
                        state_ff <= ST_WAIT;
                        start_ff <= START_LOAD;
                    end
                ST_WAIT:
                    if (start_ff != 2'h0)
                        start_ff <= start_ff - 2'h1;
                    else if (bus_grant && fifo_ready)
                    begin
                        state_ff <= ST_READ;
                        acc_ff   <= bsc_wait_states;
                    end
                ST_READ:
                    if (acc_ff != '0)
                        acc_ff <= acc_ff - 1'b1;
                    else
                    begin
                        state_ff <= ST_WRITE;
                        acc_ff   <= bsc_wait_states;
                    end
                ST_WRITE:
                    if (acc_ff != '0)
                        acc_ff <= acc_ff - 1'b1;
                    else
                        state_ff <= ST_GAP;
                ST_GAP:
                    if (pend_ff != 2'h0 || accept)
                    begin
                        state_ff <= ST_WAIT;
                        start_ff <= 2'h0;
                    end
                    else
                        state_ff <= ST_IDLE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Cycle-steal or idle burst releases the bus
    assign bus_request = (state_ff == ST_WAIT && start_ff == 2'h0) || state_ff == ST_READ
                       || state_ff == ST_WRITE || (state_ff == ST_GAP && is_burst && pend_ff != 2'h0);

    always_comb
    begin
        area_chip_select_n = !(state_ff == ST_READ || state_ff == ST_WRITE);
        dma_ack_pin        = !area_chip_select_n && ((state_ff == ST_WRITE) == ack_on_write[cur_ff]);
    end

    generate
        for (genvar c = 0; c < NCH; c++)
        begin : g_ch
            logic done_here;
            logic te_ff;

            assign done_here   = unit_done && active_ff && cur_ff == IW'(c);
            assign eligible[c] = master_enable && channel_enable[c] && !nmi_abort_flag
                               && !te_ff && count_ff[c] != '0;
            assign transfer_end_flag[c] = te_ff;

            always_ff @(posedge clk)
            begin
                if (srst)
                    count_ff[c] <= '0;
                else if (count_load[c])
                    count_ff[c] <= count_load_value;
                else if (done_here && count_ff[c] != '0)
                    count_ff[c] <= count_ff[c] - 1'b1;
            end

            // Set wins over clear
            always_ff @(posedge clk)
            begin
                if (srst)
                    te_ff <= 1'b0;
                else if (done_here && count_ff[c] == CW'(1))
                    te_ff <= 1'b1;
                else if (end_flag_clear[c])
                    te_ff <= 1'b0;
            end
        end
    endgenerate

    assign transfer_end_interrupt = |(transfer_end_flag & end_interrupt_enable);

    // Abort flag, set wins over clear
    always_ff @(posedge clk)
    begin
        if (srst)
            nmi_abort_flag <= 1'b0;
        else if (nmi_event)
            nmi_abort_flag <= 1'b1;
        else if (nmi_flag_clear)
            nmi_abort_flag <= 1'b0;
    end

    logic ch2_done;
    logic reload_reset;

    assign ch2_done     = unit_done && active_ff && cur_ff == IW'(RELOAD_CH);
    assign reload_reset = !master_enable || !channel_enable[RELOAD_CH] || nmi_event
                        || standby || transfer_end_flag[RELOAD_CH];

    always_ff @(posedge clk)
    begin
        if (srst || reload_reset)
            reload_cnt_ff <= 2'h0;
        else if (ch2_done && reload_enable)
            reload_cnt_ff <= reload_cnt_ff + 2'h1;
    end

    // Address survives every abort; only a software load or the fourth-transfer reload restores it
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ch2_prog_ff        <= '0;
            ch2_source_address <= '0;
        end
        else if (ch2_source_load)
        begin
            ch2_prog_ff        <= ch2_source_value;
            ch2_source_address <= ch2_source_value;
        end
        else if (ch2_done)
        begin
            if (reload_enable && reload_cnt_ff == RELOAD_LAST)
                ch2_source_address <= ch2_prog_ff;
            else
                ch2_source_address <= ch2_source_address + ADDR_STEP;
        end
    end

    dma_xfer_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (state_ff == ST_READ && acc_ff == '0),
        .in_ready  (fifo_ready),
        .in_data   (bus_rdata),
        .out_valid (xfer_valid),
        .out_ready (xfer_ready),
        .out_data  (xfer_data)
    );

    // Checks
    a_start_delay : assert property (@(posedge clk) disable iff (srst)
        (state_ff == ST_IDLE && accept) |-> ##1 (state_ff != ST_READ) ##1 (state_ff != ST_READ))
        else $error("transfer started too early");
    a_second_gap : assert property (@(posedge clk) disable iff (srst)
        accept |=> !accept)
        else $error("second sample too soon");
    a_ack_match : assert property (@(posedge clk) disable iff (srst)
        dma_ack_pin |-> !area_chip_select_n)
        else $error("ack outside chip select");
    a_write_follows : assert property (@(posedge clk) disable iff (srst)
        (state_ff == ST_READ && acc_ff == '0) |=> state_ff == ST_WRITE)
        else $error("write not after read");
    a_pend_bound : assert property (@(posedge clk) disable iff (srst)
        pend_ff == PEND_MAX |-> !accept)
        else $error("sampling ran too far ahead");
    a_end_flag : assert property (@(posedge clk) disable iff (srst)
        (last_unit && !end_flag_clear[cur_ff]) |=> transfer_end_flag[$past(cur_ff)])
        else $error("end flag not set at count zero");
    a_nmi_flag : assert property (@(posedge clk) disable iff (srst)
        nmi_event |=> nmi_abort_flag && !sample_now)
        else $error("abort flag missing");
    a_no_accept_stop : assert property (@(posedge clk) disable iff (srst)
        !run_ok |-> !accept)
        else $error("request taken after ending");
    a_reload_clear : assert property (@(posedge clk) disable iff (srst)
        $fell(master_enable) |=> reload_cnt_ff == 2'h0)
        else $error("reload counter not cleared");
    a_reload_addr : assert property (@(posedge clk) disable iff (srst)
        (ch2_done && reload_enable && reload_cnt_ff == RELOAD_LAST && !ch2_source_load)
        |=> ch2_source_address == ch2_prog_ff)
        else $error("reload address wrong");
    a_count_step : assert property (@(posedge clk) disable iff (srst)
        (unit_done && !count_load[cur_ff] && count_ff[cur_ff] != '0)
        |=> count_ff[$past(cur_ff)] == $past(count_ff[cur_ff]) - 1'b1)
        else $error("count did not step");

    c_unit_done : cover property (@(posedge clk) disable iff (srst) unit_done);
    c_end_flag  : cover property (@(posedge clk) disable iff (srst) last_unit);
    c_nmi_stop  : cover property (@(posedge clk) disable iff (srst) nmi_event && active_ff);
    c_reload    : cover property (@(posedge clk) disable iff (srst) ch2_done && reload_cnt_ff == RELOAD_LAST);
endmodule
`default_nettype wire

/* File: tb/dma_peripheral_model.sv */
// Peripheral model driving the active-low request pin.
// Assumes the bench raises go while it wants transfers; pin idles high.
`timescale 1ns/1ps
`default_nettype none
module dma_peripheral_model (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic go,
    input  wire logic edge_mode,
    output logic      dma_request_pin_n
);
    logic [2:0] phase_ff;
    always_ff @(posedge clk)
    begin
        if (srst || !go)
            phase_ff <= 3'h0;
        else
            phase_ff <= (phase_ff == 3'h4) ? 3'h0 : phase_ff + 3'h1;
    end
    // Edge mode: fresh edge every five states while go stays high
    // Two low states so each edge survives the two-flop sync
    assign dma_request_pin_n = !go || (edge_mode && phase_ff > 3'h1);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the DMA request control block.
// Assumes one 40 MHz clock; grant follows bus request one state late.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    import dma_ctrl_pkg::*;
    logic        clk, srst, pin_n, ack, cs_n, breq, grant, men, irq, nmi_ev, nmi_clr, nmi_flag;
    logic        ro, src_load, xvalid, xready, go, edge_mode, hold_ready, cs_q, stby;
    logic [3:0]  wst, ch_en, mode, edet, aow, ie, cload, fclr, tflag;
    logic [15:0] cval;
    logic [31:0] rdata, src_val, src_addr, xdata, exp_d;
    logic [31:0] notes[$];
    int          mismatches, n_checks, cyc, units, cs_cyc, ack_cyc;

    dma_request_control u_dut (
        .clk(clk), .srst(srst), .dma_request_pin_n(pin_n), .dma_ack_pin(ack),
        .area_chip_select_n(cs_n), .bus_request(breq), .bus_grant(grant), .bsc_wait_states(wst),
        .bus_rdata(rdata), .master_enable(men), .channel_enable(ch_en), .bus_mode_select(mode),
        .edge_detect(edet), .ack_on_write(aow), .end_interrupt_enable(ie), .count_load(cload),
        .count_load_value(cval), .end_flag_clear(fclr), .transfer_end_flag(tflag),
        .transfer_end_interrupt(irq), .nmi_event(nmi_ev), .nmi_flag_clear(nmi_clr),
        .nmi_abort_flag(nmi_flag), .standby(stby), .reload_enable(ro), .ch2_source_load(src_load),
        .ch2_source_value(src_val), .ch2_source_address(src_addr), .xfer_valid(xvalid),
        .xfer_ready(xready), .xfer_data(xdata)
    );
    dma_peripheral_model u_periph (
        .clk(clk), .srst(srst), .go(go), .edge_mode(edge_mode), .dma_request_pin_n(pin_n)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Grant lags request so the engine must really wait for it
    always @(posedge clk)
    begin
        grant <= breq;
        xready <= !hold_ready && ($urandom % 4 != 0);
    end

    // Watcher: bus activity counts and stream comparison
    always @(posedge clk)
    begin
        cyc++;
        if (cs_n === 1'b0) cs_cyc++;
        if (ack === 1'b1) ack_cyc++;
        if (cs_n === 1'b0 && cs_q === 1'b1) units++;
        cs_q = cs_n;
        if (xvalid === 1'b1 && xready === 1'b1)
        begin
            exp_d = (notes.size() > 0) ? notes.pop_front() : ~xdata;
            `CHK("xfer_data", exp_d, xdata)
        end
        if (cyc > 60000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_flag(int ch);
        int k;
        k = 0;
        while (tflag[ch] !== 1'b1 && k < 3000)
        begin
            tick(1);
            k++;
        end
    endtask

    task automatic start(int ch, int n, bit push);
        units = 0;
        cs_cyc = 0;
        ack_cyc = 0;
        @(posedge clk);
        cload[ch] <= 1'b1;
        cval <= 16'(n);
        edge_mode <= edet[ch];
        if (push) repeat (n) notes.push_back(rdata);
        @(posedge clk);
        cload <= 4'h0;
        ch_en[ch] <= 1'b1;
        go <= 1'b1;
    endtask

    task automatic stop(int ch, string nm);
        int k;
        go <= 1'b0;
        ch_en[ch] <= 1'b0;
        @(posedge clk);
        fclr <= 4'hf;
        @(posedge clk);
        fclr <= 4'h0;
        k = 0;
        while (notes.size() > 0 && k < 3000)
        begin
            tick(1);
            k++;
        end
        // Flag clear lands in this step; look one state later
        tick(1);
        `CHK("notes left", 0, notes.size())
        `CHK("irq after clear", 1'b0, irq)
        $display("test %s done", nm);
    endtask

    task automatic run_mode(int m);
        int ch, n, w, k;
        ch = m % 2;
        n = 4 + m;
        w = $urandom % 4;
        @(posedge clk);
        mode[ch] <= m[1];
        edet[ch] <= m[0];
        aow[ch] <= m[0] ^ m[1];
        ie[ch] <= (m != 3);
        wst <= 4'(w);
        rdata <= $urandom;
        start(ch, n, 1'b1);
        k = 0;
        while (cs_n !== 1'b0 && k < 100)
        begin
            tick(1);
            k++;
        end
        `CHK("start delay", 1'b1, k >= START_STATES)
        // Burst edge must carry on with the pin left high
        if (m == 3) go <= 1'b0;
        wait_flag(ch);
        tick(4);
        `CHK("end flag", 1'b1, tflag[ch])
        `CHK("end irq", m != 3, irq)
        `CHK("units", n, units)
        `CHK("ack span", cs_cyc, 2 * ack_cyc)
        `CHK("access states", n * 2 * (w + 1), cs_cyc)
        stop(ch, "mode");
    endtask

    task automatic abort_run(int kind);
        int u, k;
        @(posedge clk);
        mode[0] <= 1'b1;
        edet[0] <= 1'b0;
        wst <= 4'h0;
        rdata <= $urandom;
        start(0, 16, 1'b1);
        k = 0;
        while (units < 3 && k < 500)
        begin
            tick(1);
            k++;
        end
        if (kind == 0) ch_en[0] <= 1'b0;
        if (kind == 1) nmi_ev <= 1'b1;
        if (kind == 2) men <= 1'b0;
        if (kind == 3) go <= 1'b0;
        tick(1);
        nmi_ev <= 1'b0;
        tick(30);
        u = units;
        tick(20);
        `CHK("stopped", u, units)
        `CHK("short run", 1'b1, u < 16)
        `CHK("bus released", 1'b0, breq)
        `CHK("flag clear", 1'b0, tflag[0])
        `CHK("whole units", u * 2, cs_cyc)
        if (kind == 1) `CHK("abort flag", 1'b1, nmi_flag)
        if (kind == 0)
        begin
            `CHK("units out", 16 - u, notes.size())
            notes.delete();
        end
        else
        begin
            nmi_clr <= 1'b1;
            men <= 1'b1;
            go <= 1'b1;
            tick(1);
            nmi_clr <= 1'b0;
            wait_flag(0);
            tick(4);
            `CHK("resumed units", 16, units)
        end
        stop(0, "abort");
    endtask

    task automatic reload_run(bit on, int n, logic [31:0] off, int sb);
        logic [31:0] a;
        int k;
        a = $urandom & 32'hffff_ff00;
        k = 0;
        @(posedge clk);
        ro <= on;
        src_load <= 1'b1;
        src_val <= a;
        mode[2] <= 1'b0;
        edet[2] <= 1'b0;
        @(posedge clk);
        src_load <= 1'b0;
        start(2, n, 1'b1);
        // Standby mid-run restarts the four-transfer count
        while (sb > 0 && units < sb && k < 500)
        begin
            tick(1);
            k++;
        end
        if (sb > 0)
        begin
            stby <= 1'b1;
            tick(1);
            stby <= 1'b0;
        end
        wait_flag(2);
        tick(4);
        `CHK("source address", a + off, src_addr)
        stop(2, "reload");
    endtask

    task automatic fifo_run();
        @(posedge clk);
        hold_ready <= 1'b1;
        mode[1] <= 1'b0;
        edet[1] <= 1'b0;
        start(1, 12, 1'b1);
        tick(300);
        `CHK("fill stop", FIFO_DEPTH, units)
        `CHK("valid held", 1'b1, xvalid)
        hold_ready <= 1'b0;
        wait_flag(1);
        tick(4);
        `CHK("all units", 12, units)
        stop(1, "fifo");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        {srst, cs_q} = 2'b11;
        {go, edge_mode, hold_ready, men, nmi_ev, nmi_clr, ro, src_load, grant, xready, stby} = '0;
        {ch_en, mode, edet, aow, ie, cload, fclr, wst} = '0;
        {cval, rdata, src_val} = '0;
        void'($urandom(33395));
        tick(5);
        srst <= 1'b0;
        men <= 1'b1;
        for (int m = 0; m < 4; m++) run_mode(m);
        for (int k = 0; k < 4; k++) abort_run(k);
        // Count kept a multiple of four while reload is on
        reload_run(1'b1, 2 * RELOAD_PERIOD, 32'h0, 0);
        reload_run(1'b1, 2 * RELOAD_PERIOD, 32'h4, 2);
        reload_run(1'b0, 4, 32'h8, 0);
        fifo_run();
        finish_test();
    end
endmodule
`default_nettype wire
